// ### src/clk_ctl_device.sv
// Clock controller: PLL enable and relock, lock flag, mode gating, deep-sleep overrides.
// Assumes mosc_pin toggles at the main oscillator rate, well below clk.
`timescale 1ns/10ps
module clk_ctl_device #(
  parameter logic [12:0] RELOCK_LOAD = clk_ctl_pkg::RELOCK_START,
  parameter int GW = clk_ctl_pkg::GATE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration link
  clk_ctl_if.dev link,
  // Main oscillator pin, asynchronous
  input wire logic mosc_pin,
  // Clock tree controls
  output logic core_clk_en,
  output logic [GW-1:0] periph_clk_en,
  output logic pll_powered,
  output logic use_pll,
  output logic [1:0] osc_sel,
  output logic div_en,
  output logic [5:0] divisor_eff,
  output logic mosc_powered,
  output logic iosc_powered
);

  // ---------------------------------------------------------------
  // Crystal translation
  // ---------------------------------------------------------------
  // Result is {reference divider 5b (fixed 0), multiplier 11b}, rounded
  function automatic logic [15:0] xlate(input logic [3:0] x);
    int unsigned khz;
    int unsigned f;
    khz = clk_ctl_pkg::CRYSTAL_SELECT_KHZ[x];
    f = (clk_ctl_pkg::VCO_TARGET_KHZ + khz / 2) / khz;
    return {5'h00, f[10:0]};
  endfunction : xlate

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  clk_ctl_pkg::mode_t mode_q, mode_d;
  logic [2:0] mosc_sync_q, mosc_sync_d;
  logic [12:0] cnt_q, cnt_d;
  logic [3:0] crystal_select_q, crystal_select_d;
  logic pd_prev_q, pd_prev_d;
  logic flag_q, flag_d;
  logic ds_pll_q, ds_pll_d;
  logic ds_ext_q, ds_ext_d;
  logic [15:0] trans_q, trans_d;
  logic core_q, core_d;
  logic [GW-1:0] gate_q, gate_d;
  logic pll_on_q, pll_on_d;
  logic use_pll_q, use_pll_d;
  logic [1:0] osc_q, osc_d;
  logic div_en_q, div_en_d;
  logic [5:0] div_q, div_d;
  logic mosc_on_q, mosc_on_d;
  logic iosc_on_q, iosc_on_d;

  logic eff_bypass;
  logic [1:0] eff_osc;
  logic eff_pd;
  logic [5:0] eff_div;
  logic pd_act;
  logic tick;
  logic trig;
  logic locked;
  logic lock_ev;
  logic deep_ovr;

  // ---------------------------------------------------------------
  // Relock and lock flag
  // ---------------------------------------------------------------
  always_comb begin
    eff_bypass = link.ext_config_select ? link.ext_bypass : link.bypass;
    eff_osc = link.ext_config_select ? link.ext_oscillator_source : link.oscillator_source;
    eff_pd = link.ext_config_select ? link.ext_pll_power_down : link.pll_power_down;
    eff_div = link.ext_config_select ? link.ext_sysclk_divisor : {2'b00, link.sysclk_divisor};
    // Deep-sleep forces the PLL down regardless of configuration
    pd_act = eff_pd | (mode_q == clk_ctl_pkg::MODE_DEEP);
    mosc_sync_d = {mosc_sync_q[1:0], mosc_pin};
    tick = mosc_sync_q[1] & ~mosc_sync_q[2];
    // Same-value rewrites leave crystal_select_q equal, so no relock
    trig = (link.crystal_select != crystal_select_q) | (pd_prev_q & ~pd_act);
    crystal_select_d = link.crystal_select;
    pd_prev_d = pd_act;
    cnt_d = cnt_q;
    if (trig) begin
      cnt_d = RELOCK_LOAD;
    end else if (tick && !pd_act && cnt_q != 13'h0000) begin
      cnt_d = cnt_q - 13'h0001;
    end
    locked = (cnt_q == 13'h0000) & ~trig & ~pd_act;
    lock_ev = tick & ~trig & ~pd_act & (cnt_q == 13'h0001);
    // Set wins over a clear in the same cycle
    flag_d = lock_ev | (flag_q & ~link.lock_flag_clr);
    trans_d = xlate(link.crystal_select);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mosc_sync_q <= 3'h0;
      cnt_q <= 13'h0000;
      crystal_select_q <= clk_ctl_pkg::CRYSTAL_SELECT_RST;
      pd_prev_q <= 1'b1;
      flag_q <= 1'b0;
      trans_q <= 16'h0000;
    end else begin
      mosc_sync_q <= mosc_sync_d;
      cnt_q <= cnt_d;
      crystal_select_q <= crystal_select_d;
      pd_prev_q <= pd_prev_d;
      flag_q <= flag_d;
      trans_q <= trans_d;
    end
  end

  // ---------------------------------------------------------------
  // Power modes and clock tree
  // ---------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    ds_pll_d = ds_pll_q;
    ds_ext_d = ds_ext_q;
    case (mode_q)
      clk_ctl_pkg::MODE_RUN: begin
        if (link.deep_req) begin
          mode_d = clk_ctl_pkg::MODE_DEEP;
          ds_pll_d = ~eff_pd;
          ds_ext_d = link.ext_config_select;
        end else if (link.sleep_req) begin
          mode_d = clk_ctl_pkg::MODE_SLEEP;
        end
      end
      clk_ctl_pkg::MODE_SLEEP: begin
        if (link.wake_irq) begin
          mode_d = clk_ctl_pkg::MODE_RUN;
        end
      end
      clk_ctl_pkg::MODE_DEEP: begin
        if (link.wake_irq) begin
          mode_d = clk_ctl_pkg::MODE_WAKE;
        end
      end
      clk_ctl_pkg::MODE_WAKE: begin
        // Hold peripherals until the entry clock is back and stable
        if (!ds_pll_q || eff_bypass || locked) begin
          mode_d = clk_ctl_pkg::MODE_RUN;
        end
      end
      default: mode_d = clk_ctl_pkg::MODE_RUN;
    endcase

    deep_ovr = (mode_q == clk_ctl_pkg::MODE_DEEP);
    core_d = (mode_d == clk_ctl_pkg::MODE_RUN);
    case (mode_d)
      clk_ctl_pkg::MODE_SLEEP: gate_d = link.auto_gate ? link.sleep_gate_regs : link.run_gate_regs;
      clk_ctl_pkg::MODE_DEEP, clk_ctl_pkg::MODE_WAKE:
        gate_d = link.auto_gate ? link.deep_sleep_gate_regs : link.run_gate_regs;
      default: gate_d = link.run_gate_regs;
    endcase
    pll_on_d = ~pd_act;
    // Oscillator feeds sysclk until lock with bypass clear, then the PLL takes over
    use_pll_d = locked & ~eff_bypass;
    if (deep_ovr) begin
      osc_d = link.deep_sleep_clock_config;
      div_en_d = link.divider_use | ds_pll_q;
      div_d = ds_pll_q ? (ds_ext_q ? clk_ctl_pkg::DS_DIV_EXT : clk_ctl_pkg::DS_DIV_BASE) : eff_div;
    end else begin
      osc_d = eff_osc;
      div_en_d = link.divider_use & ~eff_bypass;
      div_d = eff_div;
    end
    mosc_on_d = (osc_d == clk_ctl_pkg::OSC_MAIN) | ~pd_act;
    iosc_on_d = (osc_d == clk_ctl_pkg::OSC_INT) | (osc_d == clk_ctl_pkg::OSC_INT_DIV4);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q <= clk_ctl_pkg::MODE_RUN;
      ds_pll_q <= 1'b0;
      ds_ext_q <= 1'b0;
      core_q <= 1'b1;
      gate_q <= '0;
      pll_on_q <= 1'b0;
      use_pll_q <= 1'b0;
      osc_q <= clk_ctl_pkg::OSC_MAIN;
      div_en_q <= 1'b0;
      div_q <= 6'h00;
      mosc_on_q <= 1'b1;
      iosc_on_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      ds_pll_q <= ds_pll_d;
      ds_ext_q <= ds_ext_d;
      core_q <= core_d;
      gate_q <= gate_d;
      pll_on_q <= pll_on_d;
      use_pll_q <= use_pll_d;
      osc_q <= osc_d;
      div_en_q <= div_en_d;
      div_q <= div_d;
      mosc_on_q <= mosc_on_d;
      iosc_on_q <= iosc_on_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.pll_translation = trans_q;
  assign link.pll_lock_raw_flag = flag_q;
  assign link.lock_irq = flag_q & link.lock_irq_en;
  assign link.mode = mode_q;
  assign core_clk_en = core_q;
  assign periph_clk_en = gate_q;
  assign pll_powered = pll_on_q;
  assign use_pll = use_pll_q;
  assign osc_sel = osc_q;
  assign div_en = div_en_q;
  assign divisor_eff = div_q;
  assign mosc_powered = mosc_on_q;
  assign iosc_powered = iosc_on_q;

endmodule : clk_ctl_device

// ### src/clk_ctl_pkg.sv
// Shared constants and types for the clock controller and its software-side partner.
// Assumes both ends run on one clock and meet through clk_ctl_if.
package clk_ctl_pkg;

  // ---------------------------------------------------------------
  // Widths and timing
  // ---------------------------------------------------------------
  localparam int GATE_W = 96;
  localparam logic [12:0] RELOCK_START = 13'h1200;
  localparam int unsigned VCO_TARGET_KHZ = 400000;

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] OSC_MAIN = 2'h0;
  localparam logic [1:0] OSC_INT = 2'h1;
  localparam logic [1:0] OSC_INT_DIV4 = 2'h2;
  localparam logic [1:0] OSC_SLOW = 2'h3;
  localparam logic [5:0] DS_DIV_BASE = 6'h0f;
  localparam logic [5:0] DS_DIV_EXT = 6'h3f;
  localparam logic [3:0] CRYSTAL_SELECT_RST = 4'hb;
  localparam logic [3:0] DIVISOR_RST = 4'hf;
  localparam logic [5:0] EXT_DIVISOR_RST = 6'h0f;

  // Crystal frequency per crystal_select code, in kHz
  localparam int unsigned CRYSTAL_SELECT_KHZ [16] = '{1000, 1843, 2000, 2457, 3579, 3686, 4000, 4096,
                                             4915, 5000, 5120, 6000, 6144, 7373, 8000, 8192};

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_DEEP = 2'b10,
    MODE_WAKE = 2'b11
  } mode_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000,
    SEQ_BYPASS = 3'b001,
    SEQ_CONFIG = 3'b010,
    SEQ_DIVIDE = 3'b011,
    SEQ_POLL = 3'b100,
    SEQ_RELEASE = 3'b101
  } seq_t;

endpackage : clk_ctl_pkg

// ### src/clk_ctl_if.sv
// Configuration and status signals between the clock controller and software side.
// Assumes the testbench provides a shared clock to both ends.
`timescale 1ns/10ps
interface clk_ctl_if #(parameter int GW = clk_ctl_pkg::GATE_W);
  // Base run-mode configuration
  logic bypass;
  logic divider_use;
  logic [1:0] oscillator_source;
  logic pll_power_down;
  logic [3:0] crystal_select;
  logic [3:0] sysclk_divisor;
  logic auto_gate;
  // Extended configuration
  logic ext_config_select;
  logic ext_bypass;
  logic [1:0] ext_oscillator_source;
  logic ext_pll_power_down;
  logic [5:0] ext_sysclk_divisor;
  // Gating and deep-sleep setup
  logic [GW-1:0] run_gate_regs;
  logic [GW-1:0] sleep_gate_regs;
  logic [GW-1:0] deep_sleep_gate_regs;
  logic [1:0] deep_sleep_clock_config;
  // Core requests and interrupt control
  logic sleep_req;
  logic deep_req;
  logic wake_irq;
  logic lock_irq_en;
  logic lock_flag_clr;
  // Status back to software
  logic [15:0] pll_translation;
  logic pll_lock_raw_flag;
  logic lock_irq;
  logic [1:0] mode;

  modport dev (
    input bypass, divider_use, oscillator_source, pll_power_down, crystal_select, sysclk_divisor,
    input auto_gate, ext_config_select, ext_bypass, ext_oscillator_source, ext_pll_power_down,
    input ext_sysclk_divisor, run_gate_regs, sleep_gate_regs, deep_sleep_gate_regs,
    input deep_sleep_clock_config, sleep_req, deep_req, wake_irq, lock_irq_en, lock_flag_clr,
    output pll_translation, pll_lock_raw_flag, lock_irq, mode
  );

  modport host (
    output bypass, divider_use, oscillator_source, pll_power_down, crystal_select, sysclk_divisor,
    output auto_gate, ext_config_select, ext_bypass, ext_oscillator_source, ext_pll_power_down,
    output ext_sysclk_divisor, run_gate_regs, sleep_gate_regs, deep_sleep_gate_regs,
    output deep_sleep_clock_config, sleep_req, deep_req, wake_irq, lock_irq_en, lock_flag_clr,
    input pll_translation, pll_lock_raw_flag, lock_irq, mode
  );
endinterface : clk_ctl_if

// ### src/clk_ctl_host.sv
// Software-side end: runs the PLL bring-up sequence and forwards core requests.
// Assumes mosc_ready comes from logic on clk and means the reference is stable.
`timescale 1ns/10ps
module clk_ctl_host #(
  parameter int GW = clk_ctl_pkg::GATE_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Configuration link
  clk_ctl_if.host link,
  // PLL bring-up command
  input wire logic cmd_start,
  input wire logic cmd_ext,
  input wire logic [3:0] cmd_crystal_select,
  input wire logic [1:0] cmd_osc,
  input wire logic [5:0] cmd_div,
  input wire logic mosc_ready,
  output logic busy,
  output logic done,
  // Static settings and core requests
  input wire logic auto_gate_in,
  input wire logic [GW-1:0] run_gate_in,
  input wire logic [GW-1:0] sleep_gate_in,
  input wire logic [GW-1:0] deep_gate_in,
  input wire logic [1:0] ds_clock_in,
  input wire logic sleep_in,
  input wire logic deep_in,
  input wire logic wake_in,
  input wire logic irq_en_in
);

  clk_ctl_pkg::seq_t st_q, st_d;
  logic byp_q, byp_d;
  logic use_q, use_d;
  logic pd_q, pd_d;
  logic [3:0] crystal_select_q, crystal_select_d;
  logic [1:0] osc_q, osc_d;
  logic [5:0] div_q, div_d;
  logic ext_q, ext_d;
  logic clr_q, clr_d;
  logic done_q, done_d;

  // ---------------------------------------------------------------
  // Bring-up sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    byp_d = byp_q;
    use_d = use_q;
    pd_d = pd_q;
    crystal_select_d = crystal_select_q;
    osc_d = osc_q;
    div_d = div_q;
    ext_d = ext_q;
    clr_d = 1'b0;
    done_d = 1'b0;
    case (st_q)
      clk_ctl_pkg::SEQ_IDLE: begin
        if (cmd_start) begin
          st_d = clk_ctl_pkg::SEQ_BYPASS;
          ext_d = cmd_ext;
        end
      end
      clk_ctl_pkg::SEQ_BYPASS: begin
        byp_d = 1'b1;
        use_d = 1'b0;
        st_d = clk_ctl_pkg::SEQ_CONFIG;
      end
      clk_ctl_pkg::SEQ_CONFIG: begin
        crystal_select_d = cmd_crystal_select;
        osc_d = cmd_osc;
        pd_d = 1'b0;
        clr_d = 1'b1;
        st_d = clk_ctl_pkg::SEQ_DIVIDE;
      end
      clk_ctl_pkg::SEQ_DIVIDE: begin
        div_d = cmd_div;
        use_d = 1'b1;
        st_d = clk_ctl_pkg::SEQ_POLL;
      end
      clk_ctl_pkg::SEQ_POLL: begin
        // Never leave bypass on an unstable reference
        if (link.pll_lock_raw_flag && mosc_ready) begin
          st_d = clk_ctl_pkg::SEQ_RELEASE;
        end
      end
      clk_ctl_pkg::SEQ_RELEASE: begin
        byp_d = 1'b0;
        done_d = 1'b1;
        st_d = clk_ctl_pkg::SEQ_IDLE;
      end
      default: st_d = clk_ctl_pkg::SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= clk_ctl_pkg::SEQ_IDLE;
      byp_q <= 1'b1;
      use_q <= 1'b0;
      pd_q <= 1'b1;
      crystal_select_q <= clk_ctl_pkg::CRYSTAL_SELECT_RST;
      osc_q <= clk_ctl_pkg::OSC_MAIN;
      div_q <= clk_ctl_pkg::EXT_DIVISOR_RST;
      ext_q <= 1'b0;
      clr_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      byp_q <= byp_d;
      use_q <= use_d;
      pd_q <= pd_d;
      crystal_select_q <= crystal_select_d;
      osc_q <= osc_d;
      div_q <= div_d;
      ext_q <= ext_d;
      clr_q <= clr_d;
      done_q <= done_d;
    end
  end

  // ---------------------------------------------------------------
  // Link drive: both register copies carry the same sequence
  // ---------------------------------------------------------------
  assign link.bypass = byp_q;
  assign link.divider_use = use_q;
  assign link.oscillator_source = osc_q;
  assign link.pll_power_down = pd_q;
  assign link.crystal_select = crystal_select_q;
  assign link.sysclk_divisor = div_q[3:0];
  assign link.auto_gate = auto_gate_in;
  assign link.ext_config_select = ext_q;
  assign link.ext_bypass = byp_q;
  assign link.ext_oscillator_source = osc_q;
  assign link.ext_pll_power_down = pd_q;
  assign link.ext_sysclk_divisor = div_q;
  assign link.run_gate_regs = run_gate_in;
  assign link.sleep_gate_regs = sleep_gate_in;
  assign link.deep_sleep_gate_regs = deep_gate_in;
  assign link.deep_sleep_clock_config = ds_clock_in;
  assign link.sleep_req = sleep_in;
  assign link.deep_req = deep_in;
  assign link.wake_irq = wake_in;
  assign link.lock_irq_en = irq_en_in;
  assign link.lock_flag_clr = clr_q;
  assign busy = (st_q != clk_ctl_pkg::SEQ_IDLE);
  assign done = done_q;

endmodule : clk_ctl_host

// ### tb/clk_ctl_asserts.sv
// Concurrent checks on the link between the clock controller ends.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`timescale 1ns/10ps
module clk_ctl_asserts #(
  parameter int MIN_LOCK = 112
) (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Link signals
  input wire logic [3:0] crystal_select,
  input wire logic pll_power_down,
  input wire logic ext_config_select,
  input wire logic ext_pll_power_down,
  input wire logic lock_irq_en,
  input wire logic lock_flag_clr,
  input wire logic sleep_req,
  input wire logic deep_req,
  input wire logic wake_irq,
  input wire logic [15:0] pll_translation,
  input wire logic pll_lock_raw_flag,
  input wire logic lock_irq,
  input wire logic [1:0] mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // ---------------------------------------------
  // Cycles since the last visible relock trigger
  // ---------------------------------------------
  // Deep-sleep exit relocks are invisible here, so only rising flags are judged
  logic pd_eff;
  logic pd_q;
  logic [3:0] crystal_select_q;
  logic [15:0] since_q;
  logic [15:0] since_d;
  assign pd_eff = ext_config_select ? ext_pll_power_down : pll_power_down;
  always_comb begin
    since_d = (since_q == 16'hffff) ? since_q : since_q + 16'h0001;
    if ((crystal_select != crystal_select_q) || (pd_q && !pd_eff)) begin
      since_d = 16'h0000;
    end
  end
  always_ff @(posedge clk) begin
    crystal_select_q <= crystal_select;
    pd_q <= srst ? 1'b1 : pd_eff;
    since_q <= srst ? 16'h0000 : since_d;
  end

  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  sequence s_deep_wake;
    mode == clk_ctl_pkg::MODE_DEEP && wake_irq ##1 mode == clk_ctl_pkg::MODE_WAKE;
  endsequence
  sequence s_back_run;
    ##[1:400] mode == clk_ctl_pkg::MODE_RUN;
  endsequence

  a_irq_follows_flag: assert property (lock_irq == (pll_lock_raw_flag && lock_irq_en))
    else $error("lock interrupt does not follow flag and enable");
  a_flag_sticky: assert property (pll_lock_raw_flag && !lock_flag_clr |=> pll_lock_raw_flag)
    else $error("lock flag dropped without a clear");
  a_lock_wait: assert property ($rose(pll_lock_raw_flag) |-> int'(since_q) >= MIN_LOCK)
    else $error("lock flag rose before the relock count ran out");
  a_xlate_update: assert property ($changed(crystal_select) |=> pll_translation != $past(pll_translation))
    else $error("translation not updated after crystal change");
  a_sleep_enter: assert property (mode == clk_ctl_pkg::MODE_RUN && sleep_req && !deep_req
    |=> mode == clk_ctl_pkg::MODE_SLEEP)
    else $error("sleep request not taken");
  a_deep_enter: assert property (mode == clk_ctl_pkg::MODE_RUN && deep_req |=> mode == clk_ctl_pkg::MODE_DEEP)
    else $error("deep-sleep request not taken");
  a_run_holds: assert property (mode == clk_ctl_pkg::MODE_RUN && !sleep_req && !deep_req
    |=> mode == clk_ctl_pkg::MODE_RUN)
    else $error("run mode left without a request");
  a_sleep_wake: assert property (mode == clk_ctl_pkg::MODE_SLEEP && wake_irq |=> mode == clk_ctl_pkg::MODE_RUN)
    else $error("interrupt did not end sleep");
  a_sleep_holds: assert property (mode == clk_ctl_pkg::MODE_SLEEP && !wake_irq
    |=> mode == clk_ctl_pkg::MODE_SLEEP)
    else $error("sleep left without an interrupt");
  a_deep_holds: assert property (mode == clk_ctl_pkg::MODE_DEEP && !wake_irq
    |=> mode == clk_ctl_pkg::MODE_DEEP)
    else $error("deep-sleep left without an interrupt");
  a_deep_exit: assert property (s_deep_wake |-> s_back_run)
    else $error("wake from deep-sleep did not reach run in time");
endmodule : clk_ctl_asserts

// ### tb/tb.sv
// Self-checking bench: host end and device end joined by the link.
// Assumes a free-running main oscillator of eight clk periods.
`timescale 1ns/10ps
module tb;
  localparam logic [95:0] RG = 96'h8000_0000_0000_0000_0000_0f0f;
  localparam logic [95:0] SG = 96'h0000_0001_0000_0000_0000_003c;
  localparam logic [95:0] DG = 96'h0000_0000_0000_0200_0000_0081;
  localparam int V = clk_ctl_pkg::VCO_TARGET_KHZ;
  logic clk, srst, mosc, cmd_start, cmd_ext, auto_g, sleep_in, deep_in, wake_in, irq_en, mosc_rdy;
  logic [3:0] cmd_crystal_select;
  logic [1:0] cmd_osc, ds_clk, osc_sel;
  logic [5:0] cmd_div, div_eff;
  logic busy, done, core_en, pll_pw, use_pll, div_en, mosc_pw, iosc_pw;
  logic [95:0] periph;
  int err_total, compares, i;

  clk_ctl_if link ();
  clk_ctl_device #(.RELOCK_LOAD(13'h0010)) clk_ctl_device_inst (.clk(clk), .srst(srst), .link(link),
    .mosc_pin(mosc), .core_clk_en(core_en), .periph_clk_en(periph), .pll_powered(pll_pw), .use_pll(use_pll),
    .osc_sel(osc_sel), .div_en(div_en), .divisor_eff(div_eff), .mosc_powered(mosc_pw), .iosc_powered(iosc_pw));
  clk_ctl_host clk_ctl_host_inst (.clk(clk), .srst(srst), .link(link), .cmd_start(cmd_start), .cmd_ext(cmd_ext),
    .cmd_crystal_select(cmd_crystal_select), .cmd_osc(cmd_osc), .cmd_div(cmd_div), .mosc_ready(mosc_rdy), .busy(busy), .done(done),
    .auto_gate_in(auto_g), .run_gate_in(RG), .sleep_gate_in(SG), .deep_gate_in(DG), .ds_clock_in(ds_clk),
    .sleep_in(sleep_in), .deep_in(deep_in), .wake_in(wake_in), .irq_en_in(irq_en));
  clk_ctl_asserts #(.MIN_LOCK(112)) clk_ctl_asserts_inst (.clk(clk), .srst(srst),
    .crystal_select(link.crystal_select), .pll_power_down(link.pll_power_down),
    .ext_config_select(link.ext_config_select), .ext_pll_power_down(link.ext_pll_power_down),
    .lock_irq_en(link.lock_irq_en), .lock_flag_clr(link.lock_flag_clr), .sleep_req(link.sleep_req),
    .deep_req(link.deep_req), .wake_irq(link.wake_irq), .pll_translation(link.pll_translation),
    .pll_lock_raw_flag(link.pll_lock_raw_flag), .lock_irq(link.lock_irq), .mode(link.mode));

  // ---------------------------------------------
  // Clocks and shared tasks
  // ---------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Oscillator phase kept unrelated to clk
  initial begin
    mosc = 1'b0;
    #7;
    forever #200 mosc = ~mosc;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [95:0] seen, input logic [95:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic finish_test;
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test

  // Full bring-up through the host sequence, then the settled PLL state
  task automatic bring(input logic [3:0] x, input logic ext, input logic [5:0] dv);
    int k, m, xk, d;
    xk = clk_ctl_pkg::CRYSTAL_SELECT_KHZ[x];
    m = (V + xk / 2) / xk;
    cmd_crystal_select = x;
    cmd_ext = ext;
    cmd_div = dv;
    cmd_start = 1'b1;
    tick(1);
    cmd_start = 1'b0;
    for (k = 0; k < 2000 && done !== 1'b1; k++) begin
      chk("early_pll", use_pll & ~link.pll_lock_raw_flag, 1'b0);
      tick(1);
    end
    chk("lock_flag", link.pll_lock_raw_flag, 1'b1);
    chk("xlate", link.pll_translation, 96'(m[10:0]));
    // Error judged from the multiplier the device reports
    d = int'(link.pll_translation[10:0]) * xk;
    d = (d > V) ? d - V : V - d;
    chk("vco_err", d * 100 <= V, 1'b1);
    tick(2);
    chk("pll_path", {pll_pw, use_pll, div_en, osc_sel}, {3'b111, clk_ctl_pkg::OSC_MAIN});
    chk("div_eff", div_eff, ext ? dv : {2'b00, dv[3:0]});
  endtask : bring

  // Deep-sleep entry with overrides, then wake and restore
  task automatic deep(input logic [1:0] ds, input logic [5:0] fd, input logic [5:0] rd);
    int k;
    ds_clk = ds;
    deep_in = 1'b1;
    tick(2);
    deep_in = 1'b0;
    chk("deep", {link.mode, core_en, periph}, {clk_ctl_pkg::MODE_DEEP, 1'b0, DG});
    chk("pll_off", {pll_pw, div_en, div_eff}, {2'b01, fd});
    chk("ds_osc", {osc_sel, mosc_pw}, {ds, ds == clk_ctl_pkg::OSC_MAIN});
    if (ds != clk_ctl_pkg::OSC_MAIN) begin
      chk("iosc_on", iosc_pw, 1'b1);
    end
    wake_in = 1'b1;
    tick(2);
    wake_in = 1'b0;
    chk("wake", {link.mode, core_en}, {clk_ctl_pkg::MODE_WAKE, 1'b0});
    for (k = 0; k < 1000 && core_en !== 1'b1; k++) begin
      tick(1);
    end
    chk("mode", link.mode, clk_ctl_pkg::MODE_RUN);
    chk("restore", {use_pll, osc_sel, div_eff}, {1'b1, clk_ctl_pkg::OSC_MAIN, rd});
  endtask : deep

  // ---------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------
  initial begin
    {srst, cmd_start, cmd_ext, auto_g, sleep_in, deep_in, wake_in, irq_en} = 8'h80;
    {cmd_crystal_select, cmd_osc, ds_clk, cmd_div} = 14'h0000;
    err_total = 0;
    compares = 0;
    mosc_rdy = 1'b0;
    tick(20);
    chk("rst", {core_en, pll_pw, use_pll, mosc_pw, link.pll_lock_raw_flag}, 5'h12);
    srst = 1'b0;
    tick(2);
    chk("run_gate", {core_en, pll_pw, periph}, {2'b10, RG});
    // Lock alone must not release bypass while the reference is not ready
    fork
      bring(4'h0, 1'b0, 6'h03);
      begin
        wait (link.pll_lock_raw_flag === 1'b1);
        tick(4);
        chk("ref_wait", {busy, use_pll}, 2'b10);
        mosc_rdy = 1'b1;
      end
    join
    for (i = 1; i < 16; i++) begin
      bring(i[3:0], 1'b0, 6'h03);
    end
    chk("irq_off", link.lock_irq, 1'b0);
    irq_en = 1'b1;
    tick(1);
    chk("irq_on", link.lock_irq, 1'b1);
    for (i = 0; i < 2; i++) begin
      auto_g = i[0];
      sleep_in = 1'b1;
      tick(2);
      sleep_in = 1'b0;
      chk("sleep", {link.mode, core_en, use_pll}, {clk_ctl_pkg::MODE_SLEEP, 2'b01});
      chk("sl_gate", periph, i ? SG : RG);
      wake_in = 1'b1;
      tick(2);
      chk("woke", {link.mode, core_en, periph}, {clk_ctl_pkg::MODE_RUN, 1'b1, RG});
      tick(2);
      wake_in = 1'b0;
      chk("wake_run", link.mode, clk_ctl_pkg::MODE_RUN);
    end
    deep(clk_ctl_pkg::OSC_INT, clk_ctl_pkg::DS_DIV_BASE, 6'h03);
    bring(4'he, 1'b1, 6'h2a);
    deep(clk_ctl_pkg::OSC_MAIN, clk_ctl_pkg::DS_DIV_EXT, 6'h2a);
    finish_test();
  end

  // Whole run needs about 2600 cycles
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
endmodule : tb
